// ---- rtl/sisp_defines.vh ----
// Constants for the serial programming command decoder
`ifndef SISP_DEFINES_VH
`define SISP_DEFINES_VH
`define SISP_OP_ENABLE 8'hAC
`define SISP_B2_ENABLE 8'h53
`define SISP_B2_ERASE 8'h80
`define SISP_B2_WR_FUSE 8'hA0
`define SISP_B2_WR_FUSEH 8'hA8
`define SISP_B2_WR_FUSEX 8'hA4
`define SISP_B2_WR_LOCK 8'hE0
`define SISP_OP_POLL 8'hF0
`define SISP_OP_LD_EXT 8'h4D
`define SISP_OP_LD_HI 8'h48
`define SISP_OP_LD_LO 8'h40
`define SISP_OP_LD_EE 8'hC1
`define SISP_OP_RD_HI 8'h28
`define SISP_OP_RD_LO 8'h20
`define SISP_OP_RD_EE 8'hA0
`define SISP_OP_RD_FUSE 8'h50
`define SISP_OP_RD_LOCK 8'h58
`define SISP_OP_RD_SIG 8'h30
`define SISP_OP_RD_CAL 8'h38
`define SISP_B2_FUSE_ALT 8'h08
`define SISP_OP_WR_PAGE 8'h4C
`define SISP_OP_WR_EE 8'hC0
`define SISP_OP_WR_EEPG 8'hC2
`define SISP_FUSE_RST 8'hFF
`define SISP_FLASH_AW 12
`define SISP_EE_AW 9
`define SISP_FLASH_WAIT_US 4500
`define SISP_EE_WAIT_US 3600
`define SISP_ERASE_WAIT_US 9000
`define SISP_CLK_MHZ 250
`endif

// ---- rtl/sisp_mem.v ----
// Byte memory with registered read port
`timescale 1ns/1ns
module sisp_mem #(
    parameter AW = 12
) (
    input wire ref_clk_in,
    input wire we_in,
    input wire [AW-1:0] waddr_in,
    input wire [7:0] wdata_in,
    input wire [AW-1:0] raddr_in,
    output reg [7:0] rdata_out
);
    reg [7:0] mem [0:(1<<AW)-1];
    always @(posedge ref_clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule

// ---- rtl/sisp_decoder.v ----
// Serial programming instruction decoder with flash and eeprom arrays
`timescale 1ns/1ns
`include "sisp_defines.vh"
// Functional notes
// RULE1 - Enable instruction required first; echo byte two during byte three. Code gates only loads and writes on enabled_out; reads answer before enable.
// RULE2 - Sample data in on rising serial clock, shift out on falling.
// RULE3 - Single eeprom byte write overwrites location, self-timed, no erase.
// RULE4 - AC 80 00 00 erases flash and eeprom to all ones.
// RULE5 - Poll returns status byte; bit zero one while busy.
// RULE6 - Programmer re-polls until busy bit reads zero.
// RULE7 - Opcode 4D captures third byte as extended flash address; the code keeps only its low four bits in ext_q, which no flash address uses.
// RULE8 - Opcode 48 writes fourth byte to high half of buffer word.
// RULE9 - Opcode 40 writes fourth byte to low half of buffer word.
// RULE10 - Programmer loads low byte before high byte of each word.
// RULE11 - Opcode C1 stores fourth byte at third byte low two bits.
// RULE12 - Opcodes 28 and 20 read flash high and low byte.
// RULE13 - Opcode 4C commits page buffer to flash page given.
// RULE14 - Opcode C2 programs eeprom page, only loaded bytes altered.
// RULE15 - Flash accesses use word addresses anywhere within page range.
// RULE16 - Opcode 50 08 reads extended fuse byte in byte four.
// RULE17 - Opcode AC A4 writes extended fuse from byte four.
// RULE18 - Programmer writes unused fuse and lock bits as one.
// RULE19 - Programmer issues eeprom page write after loading buffer.
// RULE20 - Bytes travel msb first; framing restarts every four bytes.
// RULE21 - Undefined opcodes change no memory, fuse or lock bit.
module sisp_decoder #(
    parameter FLASH_WAIT = `SISP_FLASH_WAIT_US * `SISP_CLK_MHZ,
    parameter EE_WAIT = `SISP_EE_WAIT_US * `SISP_CLK_MHZ,
    parameter ERASE_WAIT = `SISP_ERASE_WAIT_US * `SISP_CLK_MHZ,
    parameter [7:0] SIG0 = 8'h5A,
    parameter [7:0] SIG1 = 8'h3C,
    parameter [7:0] SIG2 = 8'hC3,
    parameter [7:0] CAL = 8'h80
) (
    input wire ref_clk_in,
    input wire rst_b_in,
    input wire sck_in,
    input wire sdi_in,
    output reg sdo_out,
    output reg sdo_oe_b_out,
    output reg enabled_out,
    output reg busy_poll_status_out
);
    // Signature and calibration values above are arbitrary.
    localparam ST_IDLE = 2'h0;
    localparam ST_ERASE = 2'h1;
    localparam ST_FLASH = 2'h2;
    localparam ST_EEPG = 2'h3;
    ////////////////////////////////////////////////////////////////
    reg [1:0] sck_s_q;
    reg [1:0] sdi_s_q;
    reg sck_prev_q;
    wire sck_rise = sck_s_q[1] & ~sck_prev_q;
    wire sck_fall = ~sck_s_q[1] & sck_prev_q;
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_s_q <= 2'h0;
            sdi_s_q <= 2'h0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_s_q <= {sck_s_q[0], sck_in};
            sdi_s_q <= {sdi_s_q[0], sdi_in};
            sck_prev_q <= sck_s_q[1];
        end
    end
    ////////////////////////////////////////////////////////////////
    reg [4:0] bitcnt_q;
    reg [23:0] hdr_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    reg frame_end_q;
    reg [7:0] b4_q;
    reg [1:0] rdl_q;
    wire [7:0] b1 = hdr_q[23:16];
    wire [7:0] b2 = hdr_q[15:8];
    wire [7:0] b3 = hdr_q[7:0];
    reg [1:0] st_q;
    reg [31:0] tmr_q;
    reg [7:0] fuse_lo_q, fuse_hi_q, fuse_ex_q, lock_q;
    reg [3:0] ext_q;
    reg [7:0] pbuf_lo [0:7];
    reg [7:0] pbuf_hi [0:7];
    reg [7:0] ebuf [0:3];
    reg [3:0] eload_q;
    reg [11:0] page_q;
    reg [8:0] epage_q;
    reg [12:0] ecnt_q;
    wire erasing = ~ecnt_q[12];
    wire busy = (st_q != ST_IDLE) || (tmr_q != 32'h0) || erasing;
    // Read data selected by header bytes; memory has one cycle latency
    wire [7:0] f_rd, e_rd;
    reg [11:0] f_ra;
    reg [8:0] e_ra;
    reg f_we, e_we;
    reg [11:0] f_wa;
    reg [8:0] e_wa;
    reg [7:0] f_wd, e_wd;
    function [7:0] rd_sel;
        input [23:0] h;
        input [7:0] fd, ed;
        input bz;
        input [7:0] flo, fhi, fex, lk;
        begin
            rd_sel = 8'h00;
            if (h[23:16] == `SISP_OP_POLL) begin
                rd_sel = {7'h00, bz}; // RULE5
            end else if (h[23:16] == `SISP_OP_RD_HI ||
                         h[23:16] == `SISP_OP_RD_LO) begin
                rd_sel = fd; // RULE12
            end else if (h[23:16] == `SISP_OP_RD_EE) begin
                rd_sel = ed;
            end else if (h[23:16] == `SISP_OP_RD_FUSE) begin
                rd_sel = (h[15:8] == `SISP_B2_FUSE_ALT) ? fex : flo; // RULE16
            end else if (h[23:16] == `SISP_OP_RD_LOCK) begin
                rd_sel = (h[15:8] == `SISP_B2_FUSE_ALT) ? fhi : lk;
            end else if (h[23:16] == `SISP_OP_RD_SIG) begin
                rd_sel = (h[1:0] == 2'h0) ? SIG0 :
                         (h[1:0] == 2'h1) ? SIG1 : SIG2;
            end else if (h[23:16] == `SISP_OP_RD_CAL) begin
                rd_sel = CAL;
            end
        end
    endfunction
    always @* begin
        // RULE15
        f_ra = {b2[2:0], b3, (b1 == `SISP_OP_RD_HI)};
        e_ra = {b2[0], b3};
        if (st_q == ST_FLASH) begin
            f_ra = 12'h000;
        end
    end
    ////////////////////////////////////////////////////////////////
    integer i;
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bitcnt_q <= 5'h00;
            hdr_q <= 24'h000000;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            frame_end_q <= 1'b0;
            b4_q <= 8'h00;
            sdo_out <= 1'b0;
            sdo_oe_b_out <= 1'b1;
            enabled_out <= 1'b0;
            busy_poll_status_out <= 1'b0;
            fuse_lo_q <= `SISP_FUSE_RST;
            fuse_hi_q <= `SISP_FUSE_RST;
            fuse_ex_q <= `SISP_FUSE_RST;
            lock_q <= `SISP_FUSE_RST;
            ext_q <= 4'h0;
            eload_q <= 4'h0;
            st_q <= ST_IDLE;
            tmr_q <= 32'h0;
            page_q <= 12'h000;
            epage_q <= 9'h000;
            rdl_q <= 2'h0;
            for (i = 0; i < 8; i = i + 1) begin
                pbuf_lo[i] <= 8'hFF;
                pbuf_hi[i] <= 8'hFF;
            end
            for (i = 0; i < 4; i = i + 1) begin
                ebuf[i] <= 8'hFF;
            end
        end else begin
            frame_end_q <= 1'b0;
            busy_poll_status_out <= busy;
            sdo_oe_b_out <= 1'b0; // RULE1
            if (sck_rise) begin
                // RULE2 RULE20
                shift_q <= {shift_q[6:0], sdi_s_q[1]};
                bitcnt_q <= bitcnt_q + 5'h01;
                if (bitcnt_q[2:0] == 3'h7 && bitcnt_q != 5'h1F) begin
                    hdr_q <= {hdr_q[15:0], shift_q[6:0], sdi_s_q[1]};
                end
                if (bitcnt_q == 5'h0F) begin
                    // RULE1
                    tx_q <= {shift_q[6:0], sdi_s_q[1]};
                end else if (bitcnt_q[2:0] == 3'h7) begin
                    tx_q <= 8'h00;
                end
                if (bitcnt_q == 5'h1F) begin
                    b4_q <= {shift_q[6:0], sdi_s_q[1]};
                    frame_end_q <= 1'b1;
                end
            end
            if (sck_fall) begin
                // RULE2 RULE20
                sdo_out <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
            // Array data trails the header by two cycles, still before a fall
            rdl_q <= {rdl_q[0], sck_rise && bitcnt_q == 5'h17};
            if (rdl_q[1]) begin
                tx_q <= rd_sel(hdr_q, f_rd, e_rd, busy, fuse_lo_q,
                               fuse_hi_q, fuse_ex_q, lock_q); // RULE12
            end
            if (tmr_q != 32'h0) begin
                tmr_q <= tmr_q - 32'h1;
            end
            // Commit states last one cycle; the write port then walks
            if (st_q == ST_ERASE) begin
                st_q <= ST_IDLE;
            end else if (st_q == ST_FLASH) begin
                st_q <= ST_IDLE;
            end else if (st_q == ST_EEPG) begin
                st_q <= ST_IDLE;
                eload_q <= 4'h0; // RULE14
            end
            if (frame_end_q) begin
                if (!enabled_out) begin
                    if (b1 == `SISP_OP_ENABLE && b2 == `SISP_B2_ENABLE) begin
                        enabled_out <= 1'b1; // RULE1
                    end
                end else if (b1 == `SISP_OP_ENABLE) begin
                    if (b2 == `SISP_B2_ERASE && {b3, b4_q} == 16'h0000) begin
                        // RULE4
                        st_q <= ST_ERASE;
                        tmr_q <= ERASE_WAIT;
                        lock_q <= `SISP_FUSE_RST;
                    end else if (b2 == `SISP_B2_WR_FUSEX) begin
                        fuse_ex_q <= b4_q; // RULE17
                    end else if (b2 == `SISP_B2_WR_FUSE) begin
                        fuse_lo_q <= b4_q;
                    end else if (b2 == `SISP_B2_WR_FUSEH) begin
                        fuse_hi_q <= b4_q;
                    end else if (b2 == `SISP_B2_WR_LOCK) begin
                        lock_q <= b4_q;
                    end
                end else if (b1 == `SISP_OP_LD_EXT) begin
                    ext_q <= b3[3:0]; // RULE7
                end else if (b1 == `SISP_OP_LD_HI) begin
                    pbuf_hi[b3[2:0]] <= b4_q; // RULE8
                end else if (b1 == `SISP_OP_LD_LO) begin
                    pbuf_lo[b3[2:0]] <= b4_q; // RULE9
                end else if (b1 == `SISP_OP_LD_EE) begin
                    ebuf[b3[1:0]] <= b4_q; // RULE11
                    eload_q[b3[1:0]] <= 1'b1;
                end else if (b1 == `SISP_OP_WR_PAGE) begin
                    // RULE13
                    page_q <= {b2[3:0], b3[7:3], 3'h0};
                    st_q <= ST_FLASH;
                    tmr_q <= FLASH_WAIT;
                end else if (b1 == `SISP_OP_WR_EEPG) begin
                    // RULE14
                    epage_q <= {b2[0], b3[7:2], 2'h0};
                    st_q <= ST_EEPG;
                    tmr_q <= EE_WAIT;
                end else if (b1 == `SISP_OP_WR_EE) begin
                    tmr_q <= EE_WAIT; // RULE3
                end
                // RULE21
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // Single write port per array; page commits step widx_q
    reg [3:0] widx_q;
    reg wact_q;
    reg [1:0] wkind_q;
    reg [3:0] emask_q;
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            widx_q <= 4'h0;
            wact_q <= 1'b0;
            wkind_q <= 2'h0;
            emask_q <= 4'h0;
        end else if ((st_q == ST_FLASH || st_q == ST_EEPG) && !wact_q) begin
            wact_q <= 1'b1;
            wkind_q <= st_q;
            widx_q <= 4'h0;
            // Snapshot of loaded slots; the live mask clears for the next page
            emask_q <= eload_q;
        end else if (wact_q) begin
            widx_q <= widx_q + 4'h1;
            if ((wkind_q == ST_FLASH && widx_q == 4'hF) ||
                (wkind_q == ST_EEPG && widx_q == 4'h3)) begin
                wact_q <= 1'b0;
            end
        end
    end
    // Erase walks the arrays once; bit 12 set means idle
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ecnt_q <= 13'h1000;
        end else if (st_q == ST_ERASE) begin
            ecnt_q <= 13'h0000;
        end else if (!ecnt_q[12]) begin
            ecnt_q <= ecnt_q + 13'h0001;
        end
    end
    always @* begin
        f_we = 1'b0;
        f_wa = {page_q[10:3], 4'h0} | {8'h00, widx_q};
        f_wd = widx_q[0] ? pbuf_hi[widx_q[3:1]] : pbuf_lo[widx_q[3:1]];
        e_we = 1'b0;
        e_wa = epage_q | {7'h00, widx_q[1:0]};
        e_wd = ebuf[widx_q[1:0]];
        if (erasing) begin
            f_we = 1'b1; // RULE4
            f_wa = ecnt_q[11:0];
            f_wd = 8'hFF;
            e_we = (ecnt_q[11:9] == 3'h0);
            e_wa = ecnt_q[8:0];
            e_wd = 8'hFF;
        end else if (wact_q && wkind_q == ST_FLASH) begin
            f_we = 1'b1; // RULE13
        end else if (wact_q && wkind_q == ST_EEPG) begin
            e_we = emask_q[widx_q[1:0]]; // RULE14
        end else if (frame_end_q && enabled_out &&
                     b1 == `SISP_OP_WR_EE) begin
            e_we = 1'b1; // RULE3
            e_wa = {b2[0], b3};
            e_wd = b4_q;
        end
    end
    ////////////////////////////////////////////////////////////////
    sisp_mem #(.AW(`SISP_FLASH_AW)) u_flash (
        .ref_clk_in(ref_clk_in),
        .we_in(f_we),
        .waddr_in(f_wa),
        .wdata_in(f_wd),
        .raddr_in(f_ra),
        .rdata_out(f_rd)
    );
    sisp_mem #(.AW(`SISP_EE_AW)) u_eeprom (
        .ref_clk_in(ref_clk_in),
        .we_in(e_we),
        .waddr_in(e_wa),
        .wdata_in(e_wd),
        .raddr_in(e_ra),
        .rdata_out(e_rd)
    );
endmodule

// ---- verif/sisp_decoder_props.sv ----
// Port checks for the serial programming decoder
`timescale 1ns/1ns
module sisp_decoder_props #(
    parameter ERASE_WAIT = 600
) (
    input wire ref_clk_in,
    input wire rst_b_in,
    input wire sck_in,
    input wire sdi_in,
    input wire sdo_out,
    input wire sdo_oe_b_out,
    input wire enabled_out,
    input wire busy_poll_status_out
);
    reg sck_q;
    reg [4:0] bits_q;
    reg [2:0] hi_cnt_q;
    reg [31:0] busy_cnt_q;
    // Counts raw pin edges, so it runs ahead of the design's synchroniser
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_q <= 1'b0;
            bits_q <= 5'h00;
            hi_cnt_q <= 3'h0;
            busy_cnt_q <= 32'h0;
        end else begin
            sck_q <= sck_in;
            if (sck_in && !sck_q)
                bits_q <= bits_q + 5'h01;
            if (!sck_in)
                hi_cnt_q <= 3'h0;
            else if (hi_cnt_q != 3'h7)
                hi_cnt_q <= hi_cnt_q + 3'h1;
            if (busy_poll_status_out)
                busy_cnt_q <= busy_cnt_q + 32'h1;
            else
                busy_cnt_q <= 32'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence frame_edge;
        bits_q == 5'h00;
    endsequence
    sequence busy_held;
        busy_poll_status_out [*8];
    endsequence
    sdo_shift_a: assert property (
        (bits_q != 5'h00) && $changed(sdo_out) |-> hi_cnt_q < 3'h3)
        else $error("data out moved late in a clock high phase");
    enable_frame_a: assert property (
        $rose(enabled_out) |-> frame_edge)
        else $error("enable taken inside a frame");
    enable_hold_a: assert property (
        enabled_out |=> enabled_out)
        else $error("enable dropped without reset");
    oe_drive_a: assert property (
        $rose(enabled_out) |-> ##[0:2] !sdo_oe_b_out)
        else $error("data out not driven after enable");
    busy_frame_a: assert property (
        $rose(busy_poll_status_out) |-> frame_edge)
        else $error("busy started inside a frame");
    busy_gate_a: assert property (
        busy_poll_status_out |-> enabled_out)
        else $error("busy while not enabled");
    busy_min_a: assert property (
        $rose(busy_poll_status_out) |-> busy_held)
        else $error("busy too short");
    busy_bound_a: assert property (
        busy_cnt_q <= ERASE_WAIT + 8)
        else $error("busy never ends");
endmodule

bind sisp_decoder sisp_decoder_props #(.ERASE_WAIT(ERASE_WAIT)) props (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .sck_in(sck_in),
    .sdi_in(sdi_in),
    .sdo_out(sdo_out),
    .sdo_oe_b_out(sdo_oe_b_out),
    .enabled_out(enabled_out),
    .busy_poll_status_out(busy_poll_status_out)
);

// ---- verif/sisp_prog_model.sv ----
// Programmer model: drives serial clock and data, collects data out
`timescale 1ns/1ns
module sisp_prog_model (
    input wire ref_clk_in,
    input wire sdo_in,
    output reg sck_out,
    output reg sdi_out
);
    initial begin
        sck_out = 1'b0;
        sdi_out = 1'b0;
    end
    // Clock stands low between frames; four bytes always go whole
    task automatic xfer(input [31:0] frame, output [31:0] resp);
        integer i;
        begin
            for (i = 31; i >= 0; i = i - 1) begin
                sdi_out <= frame[i];
                repeat (4) @(posedge ref_clk_in);
                sck_out <= 1'b1;
                repeat (4) @(posedge ref_clk_in);
                resp[i] = sdo_in;
                sck_out <= 1'b0;
            end
            // Flip the idle line so a stale level is never mistaken
            sdi_out <= ~frame[0];
            repeat (8) @(posedge ref_clk_in);
        end
    endtask
endmodule

// ---- verif/sisp_decoder_test.sv ----
// Self-checking bench for the serial programming decoder
`timescale 1ns/1ns
module sisp_decoder_test;
    localparam WAIT = 600;
    // Erase timer outlasts the 4096-cycle array walk
    localparam ERASE_T = 4200;
    reg ref_clk_in = 1'b0;
    reg rst_b_in = 1'b0;
    reg miso_hold = 1'b0;
    wire sck, sdi, sdo, sdo_oe_b, enabled, busy;
    wire miso = sdo_oe_b ? miso_hold : sdo;
    integer fails = 0;
    integer total_checks = 0;
    reg [31:0] r;
    always #2 ref_clk_in = ~ref_clk_in;
    // Undriven line shows the inverse of its last driven level
    always @(posedge ref_clk_in) begin
        if (!sdo_oe_b) miso_hold <= ~sdo;
    end
    sisp_decoder #(.FLASH_WAIT(WAIT), .EE_WAIT(WAIT),
                   .ERASE_WAIT(ERASE_T)) uut (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .sck_in(sck),
        .sdi_in(sdi),
        .sdo_out(sdo),
        .sdo_oe_b_out(sdo_oe_b),
        .enabled_out(enabled),
        .busy_poll_status_out(busy)
    );
    sisp_prog_model prog (
        .ref_clk_in(ref_clk_in),
        .sdo_in(miso),
        .sck_out(sck),
        .sdi_out(sdi)
    );
    ////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: seen %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask
    task cmd(input [7:0] b1, b2, b3, b4);
        begin
            prog.xfer({b1, b2, b3, b4}, r);
            check(r[15:8], b2);
        end
    endtask
    task rd(input [7:0] b1, b2, b3, e);
        begin
            cmd(b1, b2, b3, 8'h00);
            check(r[7:0], e);
        end
    endtask
    // Keeps polling, at most 24 times, and sends nothing else until busy reads clear
    task settle;
        integer n;
        begin
            for (n = 0; n < 24 && r[0] !== 1'b0; n = n + 1)
                cmd(8'hF0, 8'h00, 8'h00, 8'h00);
            check(r[0], 1'b0);
        end
    endtask
    task poll_busy;
        begin
            cmd(8'hF0, 8'h00, 8'h00, 8'h00);
            check(r[0], 1'b1);
            settle;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_enable;
        begin
            cmd(8'hAC, 8'h80, 8'h00, 8'h00);
            check(busy, 1'b0);
            check(enabled, 1'b0);
            cmd(8'hAC, 8'h53, 8'h00, 8'h00);
            check(enabled, 1'b1);
            check(sdo_oe_b, 1'b0);
            cmd(8'hAC, 8'h53, 8'h00, 8'h00);
        end
    endtask
    task t_erase;
        begin
            cmd(8'hAC, 8'h80, 8'h00, 8'h00);
            check(busy, 1'b1);
            poll_busy;
            rd(8'h20, 8'h01, 8'h0B, 8'hFF);
            rd(8'hA0, 8'h00, 8'h05, 8'hFF);
        end
    endtask
    task t_flash;
        begin
            cmd(8'h4D, 8'h00, 8'h00, 8'h00);
            cmd(8'h40, 8'h00, 8'h03, 8'hA5);
            cmd(8'h48, 8'h00, 8'h03, 8'h5A);
            cmd(8'h40, 8'h00, 8'h07, 8'hC3);
            cmd(8'h48, 8'h00, 8'h07, 8'h3C);
            cmd(8'h4C, 8'h01, 8'h0B, 8'h00);
            poll_busy;
            rd(8'h20, 8'h01, 8'h0B, 8'hA5);
            rd(8'h28, 8'h01, 8'h0B, 8'h5A);
            rd(8'h20, 8'h01, 8'h0F, 8'hC3);
            rd(8'h28, 8'h01, 8'h0F, 8'h3C);
            rd(8'h20, 8'h01, 8'h13, 8'hFF);
        end
    endtask
    task t_eeprom;
        begin
            cmd(8'hC1, 8'h00, 8'h05, 8'h96);
            cmd(8'hC2, 8'h00, 8'h04, 8'h00);
            poll_busy;
            rd(8'hA0, 8'h00, 8'h05, 8'h96);
            rd(8'hA0, 8'h00, 8'h04, 8'hFF);
            cmd(8'hC0, 8'h00, 8'h05, 8'h21);
            poll_busy;
            rd(8'hA0, 8'h00, 8'h05, 8'h21);
        end
    endtask
    task t_fuse;
        begin
            rd(8'h50, 8'h08, 8'h00, 8'hFF);
            cmd(8'hAC, 8'hA4, 8'h00, 8'hFE);
            cmd(8'hF0, 8'h00, 8'h00, 8'h00);
            settle;
            rd(8'h50, 8'h08, 8'h00, 8'hFE);
        end
    endtask
    task t_undef;
        begin
            cmd(8'h12, 8'h34, 8'h56, 8'h78);
            cmd(8'hAC, 8'h55, 8'h00, 8'h00);
            check(busy, 1'b0);
            rd(8'h50, 8'h08, 8'h00, 8'hFE);
            rd(8'h28, 8'h01, 8'h0B, 8'h5A);
            rd(8'hA0, 8'h00, 8'h05, 8'h21);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        begin
            if (fails == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        #300000;
        fails = fails + 1;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        t_enable;
        t_erase;
        t_flash;
        t_eeprom;
        t_fuse;
        t_undef;
        report_and_stop;
    end
endmodule
